//--- rtl/abu_defines.svh
// address breakpoint unit: offsets, field positions, reset values and vectors
`ifndef ABU_DEFINES_SVH
`define ABU_DEFINES_SVH
// =====================================================
// register byte offsets
`define ABU_OFF_CTRL 12'h000
`define ABU_OFF_ADDRH 12'h004
`define ABU_OFF_ADDRL 12'h008
`define ABU_OFF_WAKE 12'h00C
`define ABU_OFF_FCLR 12'h010
`define ABU_OFF_IRQ_STAT 12'h014
`define ABU_OFF_IRQ_MASK 12'h018
// =====================================================
// field positions
`define ABU_BIT_ENABLE 7
`define ABU_BIT_ACTIVE 6
`define ABU_BIT_WAKE_EXIT 1
`define ABU_BIT_CFE 7
`define ABU_IRQ_MATCH 0
`define ABU_IRQ_WAKE 1
// =====================================================
// reset values and vectors
`define ABU_RST_BYTE 8'h00
`define ABU_RST_IRQ 2'h0
`define ABU_VEC_NORMAL 16'hFFFC
`define ABU_VEC_MONITOR 16'hFEFC
`endif

//--- rtl/abu_pkg.sv
// address breakpoint unit types
package abu_pkg;
  // =====================================================
  // cpu observation bundle
  typedef struct packed {
    logic [15:0] addr;
    logic pc_fetch;
    logic last_cycle;
    logic ret_done;
    logic in_wait;
    logic in_stop;
  } abu_cpu_t;
  // =====================================================
  // break sequence states
  typedef enum logic [1:0] {
    ABU_IDLE = 2'b00,
    ABU_PEND = 2'b01,
    ABU_SERV = 2'b10
  } abu_state_t;
endpackage

//--- rtl/abu_top.sv
// address breakpoint unit with axi4-lite register slave
// Behaviour
// R1 - enabled break plus pc address equal to breakpoint raises request
// R2 - request makes cpu take software interrupt opcode after current instruction
// R3 - vector is FFFC normally, FEFC in monitor mode
// R4 - software writing one to active bit starts a break
// R5 - match on last instruction cycle starts break at once
// R6 - return from interrupt in break routine ends break state
// R7 - enable bit 7 of control, read write, reset clears
// R8 - active bit set on match, cleared by writing zero or reset
// R9 - software clears active bit before leaving break routine
// R10 - two byte address registers, reset to zero
// R11 - during break, other flags clear only with clear enable set
// R12 - timer counter stops during break
// R13 - watchdog disabled during break when test voltage on reset pin
// R14 - break wakes from stop and sets stop wait exit flag
// R15 - exit flag reads one after break exit, write zero clears
// R16 - comparison stays active in wait mode
// R17 - software may decrement stacked return address when flag set
// R18 - only pc fetch addresses compared, no request while serviced; software setting active bit in service still raises request
`timescale 1ns/10ps
`include "abu_defines.svh"
module abu_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cpu observation, same clock
  input wire abu_pkg::abu_cpu_t cpu,
  input wire logic monitor_mode,
  // test voltage detect on reset pin, asynchronous
  input wire logic test_high_voltage,
  // outputs to system integration logic
  output logic breakpoint_request,
  output logic trap_force,
  output logic [15:0] break_vector,
  output logic break_state,
  output logic flag_clear_allowed,
  output logic timer_stop,
  output logic watchdog_disable,
  output logic stop_wake,
  output logic irq
);
  // =====================================================
  // register state
  logic enable_r;
  logic active_r;
  logic [7:0] addrh_r;
  logic [7:0] addrl_r;
  logic wake_exit_r;
  logic cfe_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  abu_pkg::abu_state_t state_r;
  abu_pkg::abu_state_t state_nxt;
  logic tv_meta_r;
  logic tv_sync_r;
  logic have_aw_r;
  logic have_w_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire;
  logic match;
  logic sw_break;
  logic start_break;
  logic low_power;

  // word address match against a given offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  // =====================================================
  // write channel capture, either order
  assign s_axi_awready = !have_aw_r && !s_axi_bvalid;
  assign s_axi_wready = !have_w_r && !s_axi_bvalid;
  assign wr_fire = have_aw_r && have_w_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw_r <= 1'b0;
      have_w_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        have_aw_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        have_w_r <= 1'b0;
      end
    end
  end

  // write response, okay or decode error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_r[11:2] <= `ABU_OFF_IRQ_MASK >> 2) ? 2'h0 : 2'h3;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr0;
  assign wr0 = wr_fire && w_strb_r[0];

  // =====================================================
  // break detection
  assign low_power = cpu.in_wait || cpu.in_stop;
  // pc-only compare, runs in wait too, blocked while serviced
  assign match = enable_r && cpu.pc_fetch && (state_r == abu_pkg::ABU_IDLE)
    && (cpu.addr == {addrh_r, addrl_r}); // R1 R16 R18
  assign sw_break = wr0 && hit(aw_addr_r, `ABU_OFF_CTRL)
    && w_data_r[`ABU_BIT_ACTIVE] && !active_r; // R4
  assign start_break = match || sw_break;

  // break sequence state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      abu_pkg::ABU_IDLE: begin
        // immediate entry when match on last cycle or in low power
        if (start_break && (cpu.last_cycle || low_power)) begin // R5
          state_nxt = abu_pkg::ABU_SERV;
        end else if (start_break) begin
          state_nxt = abu_pkg::ABU_PEND; // R2
        end
      end
      abu_pkg::ABU_PEND: begin
        if (cpu.last_cycle) begin
          state_nxt = abu_pkg::ABU_SERV; // R2
        end
      end
      abu_pkg::ABU_SERV: begin
        if (cpu.ret_done) begin
          state_nxt = abu_pkg::ABU_IDLE; // R6
        end
      end
      default: state_nxt = abu_pkg::ABU_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= abu_pkg::ABU_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // =====================================================
  // control and address registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_r <= 1'b0; // R7
      active_r <= 1'b0; // R8
      addrh_r <= `ABU_RST_BYTE; // R10
      addrl_r <= `ABU_RST_BYTE; // R10
      cfe_r <= 1'b0;
    end else begin
      if (wr0 && hit(aw_addr_r, `ABU_OFF_CTRL)) begin
        enable_r <= w_data_r[`ABU_BIT_ENABLE]; // R7
      end
      // hardware set wins over software clear
      if (match) begin
        active_r <= 1'b1; // R8
      end else if (wr0 && hit(aw_addr_r, `ABU_OFF_CTRL)) begin
        active_r <= w_data_r[`ABU_BIT_ACTIVE]; // R8 R9
      end
      if (wr0 && hit(aw_addr_r, `ABU_OFF_ADDRH)) begin
        addrh_r <= w_data_r[7:0]; // R10
      end
      if (wr0 && hit(aw_addr_r, `ABU_OFF_ADDRL)) begin
        addrl_r <= w_data_r[7:0]; // R10
      end
      if (wr0 && hit(aw_addr_r, `ABU_OFF_FCLR)) begin
        cfe_r <= w_data_r[`ABU_BIT_CFE];
      end
    end
  end

  // stop/wait exit flag, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_exit_r <= 1'b0; // R15
    end else if (start_break && low_power && state_r == abu_pkg::ABU_IDLE) begin
      wake_exit_r <= 1'b1; // R14 R15
    end else if (wr0 && hit(aw_addr_r, `ABU_OFF_WAKE) && !w_data_r[`ABU_BIT_WAKE_EXIT]) begin
      wake_exit_r <= 1'b0; // R15
    end
  end

  // =====================================================
  // interrupt status and mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= `ABU_RST_IRQ;
      irq_mask_r <= `ABU_RST_IRQ;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr0 && hit(aw_addr_r, `ABU_OFF_IRQ_STAT))
        ? w_data_r[1:0] : 2'h0)) | {stop_wake, match};
      if (wr0 && hit(aw_addr_r, `ABU_OFF_IRQ_MASK)) begin
        irq_mask_r <= w_data_r[1:0];
      end
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // =====================================================
  // test voltage synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tv_meta_r <= 1'b0;
      tv_sync_r <= 1'b0;
    end else begin
      tv_meta_r <= test_high_voltage;
      tv_sync_r <= tv_meta_r;
    end
  end

  // =====================================================
  // outputs to system integration logic
  assign breakpoint_request = (state_r == abu_pkg::ABU_PEND) || start_break; // R1
  assign trap_force = (state_nxt == abu_pkg::ABU_SERV) && (state_r != abu_pkg::ABU_SERV); // R2
  assign break_vector = monitor_mode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL; // R3
  assign break_state = (state_r == abu_pkg::ABU_SERV);
  assign flag_clear_allowed = !break_state || cfe_r; // R11
  assign timer_stop = break_state; // R12
  assign watchdog_disable = break_state && tv_sync_r; // R13
  assign stop_wake = start_break && cpu.in_stop && (state_r == abu_pkg::ABU_IDLE); // R14

  // =====================================================
  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (hit(s_axi_araddr, `ABU_OFF_CTRL)) begin
        s_axi_rdata <= {24'h000000, enable_r, active_r, 6'h00};
      end else if (hit(s_axi_araddr, `ABU_OFF_ADDRH)) begin
        s_axi_rdata <= {24'h000000, addrh_r};
      end else if (hit(s_axi_araddr, `ABU_OFF_ADDRL)) begin
        s_axi_rdata <= {24'h000000, addrl_r};
      end else if (hit(s_axi_araddr, `ABU_OFF_WAKE)) begin
        s_axi_rdata <= {30'h00000000, wake_exit_r, 1'b0};
      end else if (hit(s_axi_araddr, `ABU_OFF_FCLR)) begin
        s_axi_rdata <= {24'h000000, cfe_r, 7'h00};
      end else if (hit(s_axi_araddr, `ABU_OFF_IRQ_STAT)) begin
        s_axi_rdata <= {30'h00000000, irq_stat_r};
      end else if (hit(s_axi_araddr, `ABU_OFF_IRQ_MASK)) begin
        s_axi_rdata <= {30'h00000000, irq_mask_r};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'h3;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // =====================================================
  // assertions
  a_match_request: assert property (@(posedge aclk) disable iff (!aresetn)
    match |-> breakpoint_request) else $error("match without request"); // R1
  a_match_sets_active: assert property (@(posedge aclk) disable iff (!aresetn)
    match |=> active_r) else $error("active not set"); // R8
  a_pend_to_serv: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == abu_pkg::ABU_PEND && cpu.last_cycle) |=> break_state)
    else $error("break not entered"); // R2
  a_last_cycle_now: assert property (@(posedge aclk) disable iff (!aresetn)
    (start_break && cpu.last_cycle && state_r == abu_pkg::ABU_IDLE) |=> break_state)
    else $error("late break"); // R5
  a_rti_ends: assert property (@(posedge aclk) disable iff (!aresetn)
    (break_state && cpu.ret_done) |=> !break_state) else $error("break not ended"); // R6
  a_vector_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    break_vector == (monitor_mode ? 16'hFEFC : 16'hFFFC)) else $error("bad vector"); // R3
  a_timer_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_stop == break_state) else $error("timer not stopped"); // R12
  a_flag_guard: assert property (@(posedge aclk) disable iff (!aresetn)
    (break_state && !cfe_r) |-> !flag_clear_allowed) else $error("clear allowed"); // R11
  a_no_rematch: assert property (@(posedge aclk) disable iff (!aresetn)
    break_state |-> !match) else $error("match while serviced"); // R18
  a_wake_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_wake |=> wake_exit_r) else $error("exit flag not set"); // R14

  // =====================================================
  // register and link checks
  // request stands for the whole pending time
  a_pend_request: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == abu_pkg::ABU_PEND) |-> breakpoint_request)
    else $error("pending without request"); // R1
  // forced trap always leads into service
  a_trap_serv: assert property (@(posedge aclk) disable iff (!aresetn)
    trap_force |=> break_state)
    else $error("trap without service"); // R2
  // software start raises the request
  a_sw_request: assert property (@(posedge aclk) disable iff (!aresetn)
    (sw_break && state_r == abu_pkg::ABU_IDLE) |-> breakpoint_request)
    else $error("software break lost"); // R4
  // enable bit follows a control write of zero
  a_enable_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr0 && hit(aw_addr_r, `ABU_OFF_CTRL) && !w_data_r[`ABU_BIT_ENABLE]) |=> !enable_r)
    else $error("enable not cleared"); // R7
  // active bit cleared by a zero write when no match competes
  a_active_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr0 && hit(aw_addr_r, `ABU_OFF_CTRL) && !w_data_r[`ABU_BIT_ACTIVE] && !match)
    |=> !active_r)
    else $error("active not cleared"); // R8
  // high address byte loads the written value
  a_addrh_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr0 && hit(aw_addr_r, `ABU_OFF_ADDRH)) |=> addrh_r == $past(w_data_r[7:0]))
    else $error("high byte not loaded"); // R10
  // low address byte loads the written value
  a_addrl_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr0 && hit(aw_addr_r, `ABU_OFF_ADDRL)) |=> addrl_r == $past(w_data_r[7:0]))
    else $error("low byte not loaded"); // R10
  // flags clearable whenever no break is in service
  a_clear_open: assert property (@(posedge aclk) disable iff (!aresetn)
    !break_state |-> flag_clear_allowed)
    else $error("clear blocked"); // R11
  // watchdog only held off inside a break
  a_wdog_break: assert property (@(posedge aclk) disable iff (!aresetn)
    watchdog_disable |-> break_state)
    else $error("watchdog off outside break"); // R13
  // wake from stop comes with a request
  a_wake_request: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_wake |-> breakpoint_request)
    else $error("wake without request"); // R14
  // exit flag cleared by a zero write when no wake competes
  a_exit_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr0 && hit(aw_addr_r, `ABU_OFF_WAKE) && !w_data_r[`ABU_BIT_WAKE_EXIT]
    && !(start_break && low_power && state_r == abu_pkg::ABU_IDLE)) |=> !wake_exit_r)
    else $error("exit flag not cleared"); // R15
  // compare still live in wait mode
  a_wait_compare: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable_r && cpu.pc_fetch && cpu.in_wait && state_r == abu_pkg::ABU_IDLE
    && cpu.addr == {addrh_r, addrl_r}) |-> match)
    else $error("no match in wait"); // R16
  // data cycles never match
  a_pc_only: assert property (@(posedge aclk) disable iff (!aresetn)
    !cpu.pc_fetch |-> !match)
    else $error("match on data cycle"); // R18
endmodule

//--- testbench/abu_cpu_model.sv
// cpu core model driving the observation bundle of the breakpoint unit
`timescale 1ns/10ps
module abu_cpu_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // controls from unit and bench
  input wire logic trap_force,
  input wire logic ret_req,
  input wire logic lp_stop,
  // observation bundle
  output abu_pkg::abu_cpu_t cpu
);
  // ====================
  // two-cycle instructions, fetch then last cycle
  logic [15:0] pc_r;
  logic ph_r;
  logic svc_r;
  // pc steps per instruction, frozen in the break routine or in stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_r <= 16'h1230;
      ph_r <= 1'b0;
      svc_r <= 1'b0;
    end else begin
      ph_r <= ~ph_r;
      if (trap_force) svc_r <= 1'b1;
      else if (ret_req) svc_r <= 1'b0;
      if (ph_r && !svc_r && !lp_stop) pc_r <= pc_r + 16'h0001;
    end
  end
  // non-fetch cycles show a changing non-pc address
  assign cpu.addr = ph_r ? ~pc_r : (svc_r ? 16'hFF00 : pc_r);
  assign cpu.pc_fetch = !ph_r;
  assign cpu.last_cycle = ph_r;
  assign cpu.ret_done = ret_req && svc_r;
  assign cpu.in_wait = 1'b0;
  assign cpu.in_stop = lp_stop;
endmodule

//--- testbench/test_abu_top.sv
// self-checking bench for the address breakpoint unit
`timescale 1ns/10ps
`include "abu_defines.svh"
module test_abu_top;
  // ====================
  // stimulus and observation
  logic aclk = 0, aresetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  abu_pkg::abu_cpu_t cpu;
  logic monitor_mode = 0, test_high_voltage = 0, ret_req = 0, lp_stop = 0;
  logic breakpoint_request, trap_force, break_state, flag_clear_allowed;
  logic timer_stop, watchdog_disable, stop_wake, irq;
  logic [15:0] break_vector;
  logic seen_req = 0, seen_swi = 0, seen_wake = 0, i0;
  int miscompares = 0, num_checks = 0, cyc = 0;
  abu_top i_abu_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu, .monitor_mode,
    .test_high_voltage, .breakpoint_request, .trap_force, .break_vector, .break_state,
    .flag_clear_allowed, .timer_stop, .watchdog_disable, .stop_wake, .irq);
  abu_cpu_model i_abu_cpu_model (.aclk, .aresetn, .trap_force, .ret_req, .lp_stop, .cpu);
  // clock
  initial begin
    forever #2 aclk = ~aclk;
  end
  // sticky records of request, trap and wake outputs, plus timeout
  always @(posedge aclk) begin
    if (breakpoint_request) seen_req <= 1'b1;
    if (trap_force) seen_swi <= 1'b1;
    if (stop_wake) seen_wake <= 1'b1;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  // ====================
  // tasks
  task automatic close_out();
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  // write: each valid held until its ready stands at a rising edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ra, rw, rb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    rb = 0;
    while (!rb) begin
      #1;
      ra = s_axi_awready & s_axi_awvalid;
      rw = s_axi_wready & s_axi_wvalid;
      rb = s_axi_bvalid & s_axi_bready;
      if (rb) chk(s_axi_bresp, 32'h0);
      @(posedge aclk);
      if (ra) s_axi_awvalid <= 1'b0;
      if (rw) s_axi_wvalid <= 1'b0;
      if (rb) s_axi_bready <= 1'b0;
    end
    #1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ra, rv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rv = 0;
    while (!rv) begin
      #1;
      ra = s_axi_arready & s_axi_arvalid;
      rv = s_axi_rvalid & s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ra) s_axi_arvalid <= 1'b0;
      if (rv) s_axi_rready <= 1'b0;
    end
    #1;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  task automatic step();
    @(posedge aclk);
    #1;
  endtask
  // return from the break routine
  task automatic leave_break();
    @(posedge aclk);
    ret_req <= 1'b1;
    @(posedge aclk);
    ret_req <= 1'b0;
    #1;
    chk(break_state, 1'b0);
  endtask
  // ====================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rc(12'(i * 4), 32'h0);
    rd(12'h020, d, r);
    chk(r, 2'b11);
    test_high_voltage <= 1'b1;
    wr(`ABU_OFF_ADDRH, 8'h12);
    wr(`ABU_OFF_ADDRL, 8'h80);
    rc(`ABU_OFF_ADDRH, 32'h12);
    rc(`ABU_OFF_ADDRL, 32'h80);
    wr(`ABU_OFF_CTRL, 8'h80);
    rc(`ABU_OFF_CTRL, 32'h80);
    for (int n = 0; n < 400 && break_state !== 1'b1; n++) step();
    chk(break_state, 1'b1);
    chk({seen_req, seen_swi}, 2'b11);
    chk(cpu.addr, 16'hFF00);
    chk(break_vector, `ABU_VEC_NORMAL);
    monitor_mode <= 1'b1;
    step();
    chk(break_vector, `ABU_VEC_MONITOR);
    monitor_mode <= 1'b0;
    chk({timer_stop, watchdog_disable}, 2'b11);
    chk(flag_clear_allowed, 1'b0);
    wr(`ABU_OFF_FCLR, 8'h80);
    chk(flag_clear_allowed, 1'b1);
    rc(`ABU_OFF_CTRL, 32'hC0);
    wr(`ABU_OFF_IRQ_MASK, 8'h00);
    i0 = irq;
    wr(`ABU_OFF_IRQ_MASK, 8'h03);
    chk(i0 ^ irq, 1'b1);
    wr(`ABU_OFF_IRQ_STAT, 8'h03);
    rc(`ABU_OFF_IRQ_STAT, 32'h0);
    wr(`ABU_OFF_CTRL, 8'h80);
    rc(`ABU_OFF_CTRL, 32'h80);
    leave_break();
    chk(timer_stop, 1'b0);
    lp_stop <= 1'b1;
    wr(`ABU_OFF_CTRL, 8'h40);
    step();
    chk(break_state, 1'b1);
    chk(seen_wake, 1'b1);
    rc(`ABU_OFF_WAKE, 32'h02);
    wr(`ABU_OFF_WAKE, 8'h00);
    rc(`ABU_OFF_WAKE, 32'h0);
    lp_stop <= 1'b0;
    wr(`ABU_OFF_CTRL, 8'h00);
    leave_break();
    close_out();
  end
endmodule
